// file: rtl/fsdc_defines.svh
// Constants for the FIFO status and direct command block
`ifndef FSDC_DEFINES_SVH
`define FSDC_DEFINES_SVH
`define FSDC_ADR_FIFO_STATUS 5'h1C
`define FSDC_ADR_TX_LEN_UP 5'h1D
`define FSDC_ADR_TX_LEN_LO 5'h1E
`define FSDC_ADR_FIFO_DATA 5'h1F
`define FSDC_REG_RESET 8'h00
`define FSDC_FIFO_DEPTH 4'hC
`define FSDC_LVL_HIGH 4'h9
`define FSDC_LVL_LOW 4'h3
`define FSDC_BIT_HIGH 6
`define FSDC_BIT_LOW 5
`define FSDC_BIT_OVF 4
`define FSDC_CMD_IDLE 5'h00
`define FSDC_CMD_SWINIT 5'h03
`define FSDC_CMD_FIFO_RST 5'h0F
`define FSDC_CMD_TX 5'h10
`define FSDC_CMD_TX_CRC 5'h11
`define FSDC_CMD_DTX 5'h12
`define FSDC_CMD_DTX_CRC 5'h13
`define FSDC_CMD_SLOT 5'h14
`define FSDC_CMD_RX_BLOCK 5'h16
`define FSDC_CMD_RX_EN 5'h17
`define FSDC_CMD_RF_INT 5'h18
`define FSDC_CMD_RF_EXT 5'h19
`define FSDC_CMD_GAIN 5'h1A
`define FSDC_WIN_NS 100000
`define FSDC_CLK_MHZ 20
`define FSDC_WIN_CYC ((`FSDC_WIN_NS * `FSDC_CLK_MHZ) / 1000)
`define FSDC_EDGE_LIMIT 8'h02
`define FSDC_GAIN_MAX_STEP 2'h3
`endif

// file: rtl/fsdc_pkg.sv
// Types for the FIFO status and direct command block
package fsdc_pkg;
    typedef struct packed {
        logic valid;     // One-cycle host word strobe
        logic [7:0] word; // Address/command word
        logic [7:0] data; // Write data for address words
    } fsdc_host_t;
    typedef struct packed {
        logic start;     // One-cycle transmit start
        logic crc;       // Append CRC
        logic slot;      // One-cycle next-slot marker request
    } fsdc_tx_t;
    typedef enum logic [1:0] {
        FSDC_TX_IDLE, FSDC_TX_WAIT_DATA, FSDC_TX_WAIT_TIMER, FSDC_TX_BUSY
    } fsdc_txst_t;
    typedef enum logic [1:0] {
        FSDC_G_IDLE, FSDC_G_COUNT, FSDC_G_DECIDE
    } fsdc_gst_t;
endpackage

// file: rtl/fsdc_core.sv
// FIFO status, transmit length registers and direct command decoder
// Contract
// - Level-high flag B6 set when nine bytes held during reception.
// - Level-low flag B5 set when three bytes held during transmission.
// - Overflow flag B4 set when host writes into a full FIFO (code: in transmit only; in receive, receiver pushes set it).
// - Status bits B3:B0 report unread byte count minus one.
// - Upper length register holds count bits 11:4, resets zero.
// - Both length registers clear at transmit end of frame.
// - Lower register: count 3:0, partial bit count, partial flag.
// - Partial bit count used only when partial flag is one.
// - Code 00 is idle; code 03 acts as power-on reset.
// - Code 0F empties FIFO, clears status and collision position.
// - Codes 10 to 13 select immediate/delayed, without/with CRC.
// - Immediate transmission starts once first data byte is loaded.
// - CRC variants append CRC; others send no CRC.
// - Delayed transmission waits for the transmit timer trigger.
// - Code 14 sends next-slot marker, only in 15693 mode.
// - Code 18 measures level TX on; code 19 with TX off.
// - Code 1A counts edges over 100 us, raising threshold while >2.
// - Each gain step lowers sensitivity 5 dB, at most 15 dB.
// - Gain returns to maximum on reset or chip enable low.
// - Host word bit 7 command flag; bit 6 read; bit 5 continuous (the code ignores bit 5).
// - Block receiver holds decoder in reset until enable or TX end.
`timescale 1ns/10ps
`include "fsdc_defines.svh"
module fsdc_core (
    input wire logic clock, // 20 MHz clock
    input wire logic rst_n, // Synchronous reset, low
    input wire logic chip_en, // Chip enable; low resets
    input wire fsdc_pkg::fsdc_host_t host, // Host word and data
    input wire logic fifo_rd, // Framer takes one FIFO byte
    input wire logic rx_push, // Receiver pushes one byte
    input wire logic [7:0] rx_byte, // Received byte
    input wire logic tx_timer, // Transmit timer trigger
    input wire logic tx_eof, // Transmit end of frame sent
    input wire logic mode_15693, // ISO/IEC 15693 selected
    input wire logic rx_digital, // Digitised receiver output
    output logic [7:0] rd_data, // Register read data
    output logic [7:0] fifo_data, // FIFO head byte
    output fsdc_pkg::fsdc_tx_t tx_ctl, // Transmit control
    output logic [11:0] tx_byte_count, // Complete bytes to send
    output logic [2:0] partial_bit_count, // Bits in last byte
    output logic rx_block, // Receiver decoder held in reset
    output logic rssi_tx_on, // Pulse: measure level TX on
    output logic rssi_tx_off, // Pulse: measure level TX off
    output logic col_clear, // Pulse: clear collision position
    output logic [1:0] gain_step, // Gain reduction in 5 dB steps
    output logic gain_busy // Gain adjust running
);
    import fsdc_pkg::*;

    logic [7:0] mem [0:11];
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [3:0] level;
    logic ovf;
    logic [7:0] len_up;
    logic [7:0] len_lo;
    logic tx_dir;
    fsdc_txst_t tx_st;
    fsdc_gst_t g_st;
    logic [11:0] win_cnt;
    logic [7:0] edges;
    logic rx_q;
    logic init;
    logic is_cmd;
    logic [4:0] code;
    logic cmd_v;
    logic host_fifo_wr;
    logic fifo_wr;
    logic [7:0] wr_byte;
    logic fifo_pop;
    logic fifo_clr;
    logic full;
    logic reg_wr;

    // Reset, chip-disable and software init act alike
    assign init = !rst_n || !chip_en
        || (cmd_v && code == `FSDC_CMD_SWINIT);
    assign is_cmd = host.word[7];
    assign code = host.word[4:0];
    assign cmd_v = host.valid && is_cmd;
    assign reg_wr = host.valid && !is_cmd && !host.word[6];
    // Register 1F used as the FIFO data port
    assign host_fifo_wr = reg_wr && host.word[4:0] == `FSDC_ADR_FIFO_DATA;
    assign fifo_wr = tx_dir ? host_fifo_wr : rx_push;
    assign wr_byte = tx_dir ? host.data : rx_byte;
    assign full = level == `FSDC_FIFO_DEPTH;
    assign fifo_pop = fifo_rd && level != 4'h0;
    assign fifo_clr = cmd_v && code == `FSDC_CMD_FIFO_RST;
    assign col_clear = fifo_clr;

    always_ff @(posedge clock) begin
        if (fifo_wr && !full) begin
            mem[wr_ptr] <= wr_byte;
        end
    end

    function automatic logic [3:0] fsdc_inc(input logic [3:0] p);
        fsdc_inc = (p == `FSDC_FIFO_DEPTH - 4'h1) ? 4'h0 : p + 4'h1;
    endfunction

    always_ff @(posedge clock) begin
        if (init || fifo_clr) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            level <= 4'h0;
        end else begin
            if (fifo_wr && !full) begin
                wr_ptr <= fsdc_inc(wr_ptr);
            end
            if (fifo_pop) begin
                rd_ptr <= fsdc_inc(rd_ptr);
            end
            level <= level + {3'h0, fifo_wr && !full}
                - {3'h0, fifo_pop};
        end
    end

    // Overflow sticky until FIFO reset or init; a write into full sets it
    always_ff @(posedge clock) begin
        if (init || fifo_clr) begin
            ovf <= 1'b0;
        end else if (fifo_wr && full) begin
            ovf <= 1'b1;
        end
    end

    property p_ovf_set;
        @(posedge clock) disable iff (!rst_n)
        fifo_wr && full && !init && !fifo_clr |=> ovf;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set on write into full FIFO");

    always_ff @(posedge clock) begin
        if (init) begin
            fifo_data <= `FSDC_REG_RESET;
        end else begin
            fifo_data <= mem[rd_ptr];
        end
    end

    // Direction: transmit after a transmission command, else receive
    always_ff @(posedge clock) begin
        if (init) begin
            tx_dir <= 1'b0;
        end else if (cmd_v && (code == `FSDC_CMD_TX
                || code == `FSDC_CMD_TX_CRC || code == `FSDC_CMD_DTX
                || code == `FSDC_CMD_DTX_CRC)) begin
            tx_dir <= 1'b1;
        end else if (tx_eof) begin
            tx_dir <= 1'b0;
        end
    end

    // Transmit length registers; end of frame wins over a host write
    always_ff @(posedge clock) begin
        if (init || tx_eof) begin
            len_up <= `FSDC_REG_RESET;
            len_lo <= `FSDC_REG_RESET;
        end else if (reg_wr) begin
            if (host.word[4:0] == `FSDC_ADR_TX_LEN_UP) begin
                len_up <= host.data;
            end
            if (host.word[4:0] == `FSDC_ADR_TX_LEN_LO) begin
                len_lo <= host.data;
            end
        end
    end

    property p_len_clear;
        @(posedge clock) disable iff (!rst_n)
        tx_eof |=> len_up == `FSDC_REG_RESET && len_lo == `FSDC_REG_RESET;
    endproperty
    a_len_clear: assert property (p_len_clear)
        else $error("length registers not cleared at end of frame");

    assign tx_byte_count = {len_up, len_lo[7:4]};
    // Partial count forced to zero unless the partial flag is set
    assign partial_bit_count = len_lo[0] ? len_lo[3:1] : 3'h0;

    always_comb begin
        rd_data = 8'h00;
        case (host.word[4:0])
            `FSDC_ADR_FIFO_STATUS: begin
                rd_data[`FSDC_BIT_HIGH] = !tx_dir
                    && level == `FSDC_LVL_HIGH;
                rd_data[`FSDC_BIT_LOW] = tx_dir
                    && level == `FSDC_LVL_LOW;
                rd_data[`FSDC_BIT_OVF] = ovf;
                // Empty reads zero, so a FIFO reset leaves a clear status
                rd_data[3:0] = (level == 4'h0) ? 4'h0
                    : level - 4'h1;
            end
            `FSDC_ADR_TX_LEN_UP: rd_data = len_up;
            `FSDC_ADR_TX_LEN_LO: rd_data = len_lo;
            default: rd_data = 8'h00;
        endcase
    end

    // Transmit sequencer: immediate waits for data, delayed for timer
    always_ff @(posedge clock) begin
        if (init) begin
            tx_st <= FSDC_TX_IDLE;
            tx_ctl <= '0;
        end else begin
            tx_ctl.start <= 1'b0;
            tx_ctl.slot <= 1'b0;
            case (tx_st)
                FSDC_TX_IDLE: begin
                    if (cmd_v && (code == `FSDC_CMD_TX
                            || code == `FSDC_CMD_TX_CRC)) begin
                        tx_st <= FSDC_TX_WAIT_DATA;
                        tx_ctl.crc <= code[0];
                    end else if (cmd_v && (code == `FSDC_CMD_DTX
                            || code == `FSDC_CMD_DTX_CRC)) begin
                        tx_st <= FSDC_TX_WAIT_TIMER;
                        tx_ctl.crc <= code[0];
                    end else if (cmd_v && code == `FSDC_CMD_SLOT
                            && mode_15693) begin
                        tx_ctl.slot <= 1'b1;
                    end
                end
                FSDC_TX_WAIT_DATA: begin
                    if (level != 4'h0) begin
                        tx_ctl.start <= 1'b1;
                        tx_st <= FSDC_TX_BUSY;
                    end
                end
                FSDC_TX_WAIT_TIMER: begin
                    if (tx_timer) begin
                        tx_ctl.start <= 1'b1;
                        tx_st <= FSDC_TX_BUSY;
                    end
                end
                FSDC_TX_BUSY: begin
                    if (tx_eof) begin
                        tx_st <= FSDC_TX_IDLE;
                    end
                end
                default: tx_st <= FSDC_TX_IDLE;
            endcase
        end
    end

    // First byte in the FIFO while armed for immediate send
    sequence s_imm_armed;
        tx_st == FSDC_TX_WAIT_DATA && level != 4'h0 && !init;
    endsequence
    property p_imm_start;
        @(posedge clock) disable iff (!rst_n)
        s_imm_armed |=> tx_ctl.start && tx_st == FSDC_TX_BUSY;
    endproperty
    a_imm_start: assert property (p_imm_start)
        else $error("immediate transmission did not start");

    property p_dly_hold;
        @(posedge clock) disable iff (!rst_n)
        tx_st == FSDC_TX_WAIT_TIMER && !init
            |=> tx_ctl.start == $past(tx_timer);
    endproperty
    a_dly_hold: assert property (p_dly_hold)
        else $error("delayed transmission start not tied to timer");

    // Receiver block: explicit enable or transmit end releases it
    always_ff @(posedge clock) begin
        if (init) begin
            rx_block <= 1'b0;
        end else if (cmd_v && code == `FSDC_CMD_RX_EN) begin
            rx_block <= 1'b0;
        end else if (tx_eof) begin
            rx_block <= 1'b0;
        end else if (cmd_v && code == `FSDC_CMD_RX_BLOCK) begin
            rx_block <= 1'b1;
        end
    end

    property p_rx_release;
        @(posedge clock) disable iff (!rst_n)
        rx_block && (tx_eof || (cmd_v && code == `FSDC_CMD_RX_EN))
            |=> !rx_block;
    endproperty
    a_rx_release: assert property (p_rx_release)
        else $error("receiver block not released");

    always_ff @(posedge clock) begin
        if (init) begin
            rssi_tx_on <= 1'b0;
            rssi_tx_off <= 1'b0;
        end else begin
            rssi_tx_on <= cmd_v && code == `FSDC_CMD_RF_INT;
            rssi_tx_off <= cmd_v && code == `FSDC_CMD_RF_EXT;
        end
    end

    // Gain adjust: count edges per window, step down while noisy
    always_ff @(posedge clock) begin
        if (init) begin
            g_st <= FSDC_G_IDLE;
            gain_step <= 2'h0;
            win_cnt <= 12'h000;
            edges <= 8'h00;
            rx_q <= 1'b0;
        end else begin
            rx_q <= rx_digital;
            case (g_st)
                FSDC_G_IDLE: begin
                    if (cmd_v && code == `FSDC_CMD_GAIN) begin
                        g_st <= FSDC_G_COUNT;
                        win_cnt <= 12'h000;
                        edges <= 8'h00;
                    end
                end
                FSDC_G_COUNT: begin
                    if (rx_q != rx_digital && edges != 8'hFF) begin
                        edges <= edges + 8'h01;
                    end
                    if (win_cnt == 12'(`FSDC_WIN_CYC - 1)) begin
                        g_st <= FSDC_G_DECIDE;
                    end else begin
                        win_cnt <= win_cnt + 12'h001;
                    end
                end
                FSDC_G_DECIDE: begin
                    if (edges > `FSDC_EDGE_LIMIT
                            && gain_step != `FSDC_GAIN_MAX_STEP) begin
                        gain_step <= gain_step + 2'h1;
                        g_st <= FSDC_G_COUNT;
                        win_cnt <= 12'h000;
                        edges <= 8'h00;
                    end else begin
                        g_st <= FSDC_G_IDLE;
                    end
                end
                default: g_st <= FSDC_G_IDLE;
            endcase
        end
    end

    assign gain_busy = g_st != FSDC_G_IDLE;
    // Unlisted codes fall through every decode above untouched

    sequence s_gain_cmd;
        g_st == FSDC_G_IDLE && cmd_v && code == `FSDC_CMD_GAIN && !init;
    endsequence
    property p_gain_start;
        @(posedge clock) disable iff (!rst_n)
        s_gain_cmd |=> gain_busy && win_cnt == 12'h000 && edges == 8'h00;
    endproperty
    a_gain_start: assert property (p_gain_start)
        else $error("gain adjust did not start a fresh window");

    // Any init source may legally drop the step back to full gain
    property p_gain_cap;
        @(posedge clock) disable iff (!rst_n)
        gain_step == `FSDC_GAIN_MAX_STEP && !init
            |=> gain_step == `FSDC_GAIN_MAX_STEP;
    endproperty
    a_gain_cap: assert property (p_gain_cap)
        else $error("gain step beyond limit");
endmodule // fsdc_core

// file: test/fsdc_host_model.sv
// Host controller model driving words into the block
`timescale 1ns/10ps
module fsdc_host_model (
    input wire logic clock, // Block clock
    input wire logic [7:0] rd_data, // Read data from block
    output fsdc_pkg::fsdc_host_t host // Host word strobe
);
    import fsdc_pkg::*;
    initial host = '0;
    // Command words carry bit 7 high, code in 4:0
    task automatic put(input logic [7:0] w, input logic [7:0] d);
        @(negedge clock);
        host <= '{1'b1, w, d};
        @(negedge clock);
        // Released lines show the inverse, not the last value
        host <= '{1'b0, ~w, ~d};
    endtask
    // Address word with bit 6 set reads
    task automatic get(input logic [4:0] a, output logic [7:0] d);
        @(negedge clock);
        host <= '{1'b1, {3'b010, a}, 8'h00};
        #1 d = rd_data;
        @(negedge clock);
        host <= '{1'b0, 8'hFF, 8'hFF};
    endtask
endmodule // fsdc_host_model

// file: test/fsdc_core_tb_top.sv
// Self-checking bench for the FIFO status and command block
`timescale 1ns/10ps
module fsdc_core_tb_top;
    import fsdc_pkg::*;
    logic clock, rst_n, chip_en, fifo_rd, rx_push, tx_timer, tx_eof;
    logic mode_15693, rx_digital, rx_block, rssi_tx_on, rssi_tx_off;
    logic col_clear, gain_busy;
    logic [7:0] rx_byte, rd_data, fifo_data, r;
    logic [11:0] tx_byte_count;
    logic [2:0] partial_bit_count;
    logic [1:0] gain_step;
    logic [4:0] seen;
    logic seen_clr;
    fsdc_host_t host;
    fsdc_tx_t tx_ctl;
    int num_errors = 0;
    int compares = 0;
    // Mode, word, data, read address, read value, pulses and block
    logic [34:0] rows [12] = '{
        {1'b0, 8'h1D, 8'hA5, 5'h1D, 8'hA5, 5'h00},
        {1'b0, 8'h1E, 8'h3B, 5'h1E, 8'h3B, 5'h00},
        {1'b0, 8'h98, 8'h00, 5'h1D, 8'hA5, 5'h10},
        {1'b0, 8'h99, 8'h00, 5'h1D, 8'hA5, 5'h08},
        {1'b0, 8'h96, 8'h00, 5'h1E, 8'h3B, 5'h01},
        {1'b0, 8'h97, 8'h00, 5'h1E, 8'h3B, 5'h00},
        {1'b0, 8'h94, 8'h00, 5'h1D, 8'hA5, 5'h00},
        {1'b1, 8'h94, 8'h00, 5'h1D, 8'hA5, 5'h02},
        {1'b0, 8'h85, 8'h00, 5'h1D, 8'hA5, 5'h00},
        {1'b0, 8'h80, 8'h00, 5'h1E, 8'h3B, 5'h00},
        {1'b0, 8'h8F, 8'h00, 5'h1C, 8'h00, 5'h04},
        {1'b0, 8'h83, 8'h00, 5'h1D, 8'h00, 5'h00}};

    fsdc_core fsdc_core_i (.clock, .rst_n, .chip_en, .host, .fifo_rd,
        .rx_push, .rx_byte, .tx_timer, .tx_eof, .mode_15693, .rx_digital,
        .rd_data, .fifo_data, .tx_ctl, .tx_byte_count, .partial_bit_count,
        .rx_block, .rssi_tx_on, .rssi_tx_off, .col_clear, .gain_step,
        .gain_busy);
    fsdc_host_model fsdc_host_model_i (.clock, .rd_data, .host);

    // Sticky record so one-cycle pulses are not missed
    always @(posedge clock) begin
        seen <= seen_clr ? 5'h00 : seen | {rssi_tx_on, rssi_tx_off,
            col_clear, tx_ctl.slot, tx_ctl.start};
    end
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end

    task automatic put(input logic [7:0] w, input logic [7:0] d);
        fsdc_host_model_i.put(w, d);
    endtask
    task automatic get(input logic [4:0] a);
        fsdc_host_model_i.get(a, r);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1;
        @(negedge clock);
        s = 0;
    endtask
    // Only the recording process writes seen; this just gates it
    task automatic clear_seen();
        @(negedge clock);
        seen_clr = 1;
        @(negedge clock);
        seen_clr = 0;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        {rst_n, fifo_rd, rx_push, tx_timer, tx_eof} = '0;
        {mode_15693, rx_digital, rx_byte} = '0;
        {chip_en, seen_clr} = 2'b11;
        // Count rising edges: the clock's first step from X is a falling one
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1;
        get(5'h1E);
        chk({r, gain_step, rx_block}, 12'h000);
        foreach (rows[i]) begin
            @(negedge clock);
            mode_15693 = rows[i][34];
            clear_seen();
            put(rows[i][33:26], rows[i][25:18]);
            cyc(2);
            get(rows[i][17:13]);
            chk(r, rows[i][12:5]);
            chk({seen[4:1], rx_block},
                rows[i][4:0]);
        end
        put(8'h1D, 8'hA5);
        put(8'h1E, 8'h3B);
        chk({tx_byte_count, partial_bit_count}, 15'h529D);
        put(8'h1E, 8'h3A);
        chk(partial_bit_count, 3'h0);
        $display("test registers and commands done");
        put(8'h96, 8'h00);
        for (int i = 0; i < 4; i++) begin
            put(8'h8F, 8'h00);
            clear_seen();
            put(8'(8'h90 + i), 8'h00); // command before length
            put(8'h1D, 8'h01);
            put(8'h1E, 8'h10);
            put(8'h1F, 8'(8'h40 + i));
            cyc(3);
            chk(seen[0], i < 2);
            chk(tx_byte_count, 12'h011);
            chk(fifo_data, 8'(8'h40 + i));
            if (i >= 2) pulse(tx_timer);
            cyc(2);
            chk({seen[0], tx_ctl.crc}, {1'b1, i[0]});
            pulse(tx_eof);
            get(5'h1E);
            chk({r, tx_byte_count}, 20'h00000);
        end
        chk(rx_block, 1'b0);
        $display("test transmit commands done");
        put(8'h8F, 8'h00);
        put(8'h92, 8'h00);
        for (int i = 1; i <= 13; i++) begin
            put(8'h1F, 8'(i));
            if (i == 3) get(5'h1C);
            if (i == 3) chk(r, 8'h22);
        end
        get(5'h1C);
        chk(r, 8'h1B);
        pulse(tx_eof);
        put(8'h8F, 8'h00);
        get(5'h1C);
        chk(r, 8'h00);
        for (int i = 0; i < 9; i++) begin
            @(negedge clock);
            rx_push = 1;
            rx_byte = 8'(i);
        end
        @(negedge clock);
        rx_push = 0;
        rx_byte = 8'hFF;
        get(5'h1C);
        chk(r, 8'h48);
        pulse(fifo_rd);
        cyc(1);
        get(5'h1C);
        chk({r, fifo_data}, 16'h0701);
        $display("test fifo status done");
        // Only after silence with receivers on
        // First run sees two edges only, second toggles every cycle
        for (int k = 0; k < 2; k++) begin
            put(8'h9A, 8'h00);
            for (int n = 0; n < 9000 && (n < 4 || gain_busy); n++) begin
                @(negedge clock);
                if (k == 1 || n < 2) rx_digital = ~rx_digital;
            end
            chk({gain_step, gain_busy},
                k ? 3'h6 : 3'h0);
        end
        if (gain_busy !== 1'b0) finish_test();
        put(8'h1D, 8'h5A);
        @(negedge clock);
        chip_en = 0;
        @(negedge clock);
        chip_en = 1;
        get(5'h1D);
        chk({r, gain_step}, 10'h000);
        $display("test gain adjust done");
        finish_test();
    end
endmodule // fsdc_core_tb_top
